// >>> inc/mha_map.vh
// mha_map.vh - constants of the modem host transfer arbiter
// assumes a 50 MHz mclk; definitions only
`ifndef MHA_MAP_VH
`define MHA_MAP_VH
// ----------------------------------------------------------------
// opening sequence
// ----------------------------------------------------------------
`define MHA_OPEN_N 8'hEA
`define MHA_CLOSE_N 8'hAE
`define MHA_OPEN_I 8'h15
`define MHA_CLOSE_I 8'h51
`define MHA_CFG_N_LO 8'h80
`define MHA_CFG_N_HI 8'h9F
`define MHA_CFG_I_LO 8'h60
`define MHA_CFG_I_HI 8'h7F
`define MHA_CFG_LVL 4:3
`define MHA_CFG_PRE 2:0
// ----------------------------------------------------------------
// framing bytes and bus rx kinds
// ----------------------------------------------------------------
`define MHA_PREAMBLE 8'h55
`define MHA_START_DELIM 8'h4D
`define MHA_STOP_DELIM 8'h26
`define MHA_KIND_DATA 2'h0
// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define MHA_ST_CTS 0
`define MHA_ST_CD 1
`define MHA_ST_BAB_ON 2
`define MHA_ST_BAB_OFF 3
`define MHA_ST_TXLVL 4
`define MHA_ST_TXFULL 5
`define MHA_ST_RXFULL 6
`define MHA_ST_RXLVL 7
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MHA_CLK_MHZ 50
`define MHA_HALF_BIT_NS 16000
`define MHA_HALF_BIT_CYC (`MHA_HALF_BIT_NS * `MHA_CLK_MHZ / 1000)
`define MHA_BABBLE_UNIT_NS 2048000
`define MHA_BABBLE_UNIT_CYC (`MHA_BABBLE_UNIT_NS / 1000 * `MHA_CLK_MHZ)
`define MHA_SILENCE_MS 3000
`define MHA_SILENCE_CYC (`MHA_SILENCE_MS * 1000 * `MHA_CLK_MHZ)
`define MHA_FIFO_FULL 5'h10
`endif

// >>> verilog/mha_arbiter.v
// mha_arbiter.v - transfer arbiter between host byte link and bus
// assumes host UART/SPI framing and the analog front end lie outside,
// exchanging whole bytes as one-cycle strobes on mclk
`timescale 1ns/1ps
`include "mha_map.vh"
module mha_arbiter #(
  parameter [31:0] BABBLE_UNIT_CYC = `MHA_BABBLE_UNIT_CYC,
  parameter [31:0] SILENCE_CYC = `MHA_SILENCE_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // mode straps
  input wire spi_mode,
  input wire manch_mode,
  // host byte link
  input wire uart_rts_n,
  input wire host_rx_valid,
  input wire [7:0] host_rx_data,
  output reg host_tx_valid,
  output reg [7:0] host_tx_data,
  output reg host_tx_par,
  output reg carrier_present_out,
  output reg tx_alarm_out,
  // spi side controls and fifos
  input wire ctl_rts,
  input wire spi_tx_wr,
  input wire [8:0] spi_tx_data,
  input wire spi_rx_rd,
  output wire [8:0] spi_rx_data,
  output wire [4:0] spi_tx_level,
  output wire [4:0] spi_rx_level,
  input wire [3:0] tx_thresh,
  input wire [3:0] rx_thresh,
  input wire [7:0] babble_limit_reg,
  input wire [2:0] spi_pre_bytes,
  input wire spi_invert,
  input wire [7:0] irq_mask,
  input wire [7:0] status_clr,
  input wire irq_edge,
  input wire irq_active_high,
  output reg [7:0] status,
  output reg irq_out,
  // bus front end
  input wire carrier_valid,
  input wire bus_rx_valid,
  input wire [7:0] bus_rx_data,
  input wire [1:0] bus_rx_kind,
  input wire fsk_tx_ready,
  output reg fsk_tx_valid,
  output reg [7:0] fsk_tx_data,
  output reg fsk_tx_par,
  output reg manch_out,
  output reg manch_oe
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_PRE = 6'h02;
  localparam [5:0] S_SD = 6'h04;
  localparam [5:0] S_DATA = 6'h08;
  localparam [5:0] S_ED = 6'h10;
  localparam [5:0] S_INHIB = 6'h20;
  localparam [31:0] HALF_FULL_M1 = `MHA_HALF_BIT_CYC - 1;
  // half-bit count fits ten bits; cut on purpose
  localparam [9:0] HALF_M1 = HALF_FULL_M1[9:0];

  reg [5:0] tx_state;
  reg [2:0] pre_left;
  reg armed;
  reg [1:0] seq_idx;
  reg seq_inv;
  reg [7:0] seq_cfg;
  reg [7:0] seq_bab;
  reg u_inv;
  reg [7:0] u_cfg;
  reg [7:0] u_bab;
  reg fsk_grant;
  reg grant_q;
  reg carrier_q;
  reg pend_q;
  reg [31:0] bab_cnt;
  reg [31:0] sil_cnt;
  reg enc_busy;
  reg [7:0] enc_sh;
  reg [3:0] half_idx;
  reg [9:0] half_cnt;
  reg enc_load;
  reg [7:0] enc_byte;
  reg mpop;

  // ----------------------------------------------------------------
  // fifos: entry 0 transmit, entry 1 receive
  // ----------------------------------------------------------------
  wire [1:0] f_wr;
  wire [1:0] f_rd;
  wire [1:0] f_clr;
  wire [17:0] f_wdat;
  wire [17:0] f_rdat;
  wire [9:0] f_lvl;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : fifo
      reg [8:0] mem [0:15];
      reg [3:0] wp;
      reg [3:0] rp;
      reg [4:0] cnt;
      wire do_wr = f_wr[g] && (cnt != `MHA_FIFO_FULL);
      wire do_rd = f_rd[g] && (cnt != 5'h00);
      always @(posedge mclk) begin
        if (rst || f_clr[g]) begin
          wp <= 4'h0;
          rp <= 4'h0;
          cnt <= 5'h00;
        end else begin
          if (do_wr) begin
            mem[wp] <= f_wdat[g*9 +: 9];
            wp <= wp + 4'h1;
          end
          if (do_rd)
            rp <= rp + 4'h1;
          cnt <= cnt + {4'h0, do_wr} - {4'h0, do_rd};
        end
      end
      assign f_rdat[g*9 +: 9] = mem[rp];
      assign f_lvl[g*5 +: 5] = cnt;
    end
  endgenerate

  wire tx_empty = (f_lvl[4:0] == 5'h00);
  wire uart_m = !spi_mode && manch_mode;
  wire uart_f = !spi_mode && !manch_mode;
  wire spi_f = spi_mode && !manch_mode;
  wire inv = spi_mode ? spi_invert : u_inv;
  wire [2:0] pre_cfg = spi_mode ? spi_pre_bytes : u_cfg[`MHA_CFG_PRE];
  wire [7:0] bab_lim = spi_mode ? babble_limit_reg : u_bab;
  wire [39:0] bab_lim_cyc = bab_lim * BABBLE_UNIT_CYC;
  wire sending = (tx_state & (S_PRE | S_SD | S_DATA | S_ED)) != 6'h00;
  // babble only counts real bus time; zero limit leaves it off
  wire bab_trip = manch_mode && sending && (bab_lim != 8'h00) &&
                  ({8'h00, bab_cnt} >= bab_lim_cyc);
  wire sil_done = (sil_cnt >= SILENCE_CYC - 32'h1);
  wire host_ok = host_rx_valid && !carrier_present_out;
  wire enc_last = enc_busy && (half_idx == 4'hF) && (half_cnt == HALF_M1);
  wire enc_free = !enc_busy || enc_last;
  wire tx_start = manch_mode && (spi_mode || armed) && !tx_empty &&
                  !carrier_valid;
  wire fsk_pop = spi_f && fsk_grant && fsk_tx_ready && !tx_empty &&
                 !fsk_tx_valid;
  wire [7:0] cfg_lo = seq_inv ? `MHA_CFG_I_LO : `MHA_CFG_N_LO;
  wire [7:0] cfg_hi = seq_inv ? `MHA_CFG_I_HI : `MHA_CFG_N_HI;
  wire [7:0] close_b = seq_inv ? `MHA_CLOSE_I : `MHA_CLOSE_N;
  wire [4:0] u_thr = {2'b00, u_cfg[`MHA_CFG_LVL], 1'b0} + 5'h02;

  assign f_wr[0] = (uart_m && armed && host_ok) ||
                   (spi_mode && spi_tx_wr);
  assign f_wdat[8:0] = spi_mode ? spi_tx_data : {1'b0, host_rx_data};
  assign f_rd[0] = mpop || fsk_pop;
  assign f_clr[0] = bab_trip;
  // tag bit 8 marks framing bytes on the spi receive side
  assign f_wr[1] = spi_mode && bus_rx_valid && !(spi_f && fsk_grant);
  assign f_wdat[17:9] = {bus_rx_kind != `MHA_KIND_DATA, bus_rx_data};
  assign f_rd[1] = spi_rx_rd;
  assign f_clr[1] = 1'b0;
  assign spi_rx_data = f_rdat[17:9];
  assign spi_tx_level = f_lvl[4:0];
  assign spi_rx_level = f_lvl[9:5];

  // ----------------------------------------------------------------
  // encoder feed selection
  // ----------------------------------------------------------------
  always @* begin
    enc_load = 1'b0;
    enc_byte = `MHA_PREAMBLE;
    mpop = 1'b0;
    if (enc_free && !bab_trip) begin
      case (tx_state)
        S_PRE: enc_load = 1'b1;
        S_SD: begin
          enc_load = 1'b1;
          enc_byte = `MHA_START_DELIM;
        end
        S_DATA: begin
          enc_load = 1'b1;
          if (!tx_empty) begin
            enc_byte = f_rdat[7:0];
            mpop = 1'b1;
          end else begin
            enc_byte = `MHA_STOP_DELIM;
          end
        end
        default: enc_load = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // manchester transmit sequencer and babble timer
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      tx_state <= S_IDLE;
      pre_left <= 3'h0;
      bab_cnt <= 32'h0;
      sil_cnt <= 32'h0;
    end else begin
      bab_cnt <= sending ? bab_cnt + 32'h1 : 32'h0;
      sil_cnt <= 32'h0;
      if (bab_trip) begin
        tx_state <= S_INHIB;
      end else begin
        case (tx_state)
          S_IDLE:
            if (tx_start) begin
              tx_state <= S_PRE;
              pre_left <= pre_cfg;
            end
          S_PRE:
            if (enc_free) begin
              if (pre_left == 3'h0)
                tx_state <= S_SD;
              else
                pre_left <= pre_left - 3'h1;
            end
          S_SD:
            if (enc_free)
              tx_state <= S_DATA;
          S_DATA:
            if (enc_free && tx_empty)
              tx_state <= S_ED;
          S_ED:
            if (enc_free)
              tx_state <= S_IDLE;
          S_INHIB: begin
            sil_cnt <= sil_cnt + 32'h1;
            if (sil_done)
              tx_state <= S_IDLE;
          end
          default: tx_state <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // manchester encoder, msb first, 16 us half bits
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst || bab_trip) begin
      enc_busy <= 1'b0;
      enc_sh <= 8'h00;
      half_idx <= 4'h0;
      half_cnt <= 10'h000;
    end else if (enc_load) begin
      enc_busy <= 1'b1;
      enc_sh <= enc_byte;
      half_idx <= 4'h0;
      half_cnt <= 10'h000;
    end else if (enc_busy) begin
      if (half_cnt == HALF_M1) begin
        half_cnt <= 10'h000;
        half_idx <= half_idx + 4'h1;
        if (half_idx[0])
          enc_sh <= {enc_sh[6:0], 1'b0};
        if (half_idx == 4'hF)
          enc_busy <= 1'b0;
      end else begin
        half_cnt <= half_cnt + 10'h001;
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      manch_out <= 1'b0;
      manch_oe <= 1'b0;
    end else begin
      // first half carries the bit, so a zero rises mid-bit
      manch_out <= enc_busy & (enc_sh[7] ^ half_idx[0] ^ inv);
      manch_oe <= enc_busy;
    end
  end

  // ----------------------------------------------------------------
  // uart opening sequence parser
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      armed <= 1'b0;
      seq_idx <= 2'h0;
      seq_inv <= 1'b0;
      seq_cfg <= 8'h00;
      seq_bab <= 8'h00;
      u_inv <= 1'b0;
      u_cfg <= 8'h00;
      u_bab <= 8'h00;
    end else begin
      if (!uart_m || (tx_state == S_ED && enc_free) || bab_trip)
        armed <= 1'b0;
      if (uart_m && !armed && host_ok) begin
        case (seq_idx)
          2'h0:
            if (host_rx_data == `MHA_OPEN_N ||
                host_rx_data == `MHA_OPEN_I) begin
              seq_idx <= 2'h1;
              seq_inv <= (host_rx_data == `MHA_OPEN_I);
            end
          2'h1: begin
            seq_cfg <= host_rx_data;
            seq_idx <= (host_rx_data >= cfg_lo && host_rx_data <= cfg_hi)
                       ? 2'h2 : 2'h0;
          end
          2'h2: begin
            seq_bab <= host_rx_data;
            seq_idx <= 2'h3;
          end
          default: begin
            seq_idx <= 2'h0;
            if (host_rx_data == close_b) begin
              armed <= 1'b1;
              u_inv <= seq_inv;
              u_cfg <= seq_cfg;
              u_bab <= seq_bab;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // fsk arbitration, byte routing and pins
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      fsk_grant <= 1'b0;
      fsk_tx_valid <= 1'b0;
      fsk_tx_data <= 8'h00;
      fsk_tx_par <= 1'b0;
      host_tx_valid <= 1'b0;
      host_tx_data <= 8'h00;
      host_tx_par <= 1'b0;
      carrier_present_out <= 1'b0;
      tx_alarm_out <= 1'b0;
    end else begin
      // grant holds until released; a carrier only blocks a new grant
      fsk_grant <= !manch_mode && (spi_mode ? ctl_rts : !uart_rts_n) &&
                   (fsk_grant || !carrier_valid);
      fsk_tx_valid <= (uart_f && fsk_grant && host_rx_valid) ||
                      fsk_pop;
      if (uart_f && fsk_grant && host_rx_valid) begin
        fsk_tx_data <= host_rx_data;
        fsk_tx_par <= ~^host_rx_data;
      end else if (fsk_pop) begin
        fsk_tx_data <= f_rdat[7:0];
        fsk_tx_par <= ~^f_rdat[7:0];
      end
      host_tx_valid <= bus_rx_valid && ((uart_f && !fsk_grant) ||
                       (uart_m && bus_rx_kind == `MHA_KIND_DATA));
      if (bus_rx_valid) begin
        host_tx_data <= bus_rx_data;
        host_tx_par <= ~^bus_rx_data & uart_f;
      end
      carrier_present_out <= (uart_f && carrier_valid && !fsk_grant) ||
        (uart_m && (carrier_valid || tx_state == S_INHIB));
      tx_alarm_out <= uart_m && armed && (f_lvl[4:0] <= u_thr);
    end
  end

  // ----------------------------------------------------------------
  // spi status flags and interrupt pin
  // ----------------------------------------------------------------
  wire [7:0] st_set;
  assign st_set[`MHA_ST_CTS] = fsk_grant && !grant_q;
  assign st_set[`MHA_ST_CD] = carrier_valid && !carrier_q;
  assign st_set[`MHA_ST_BAB_ON] = bab_trip;
  assign st_set[`MHA_ST_BAB_OFF] = tx_state == S_INHIB && sil_done;
  assign st_set[`MHA_ST_TXLVL] = tx_thresh != 4'h0 &&
                                 f_lvl[4:0] <= {1'b0, tx_thresh};
  assign st_set[`MHA_ST_TXFULL] = f_lvl[4:0] == `MHA_FIFO_FULL;
  assign st_set[`MHA_ST_RXFULL] = f_lvl[9:5] == `MHA_FIFO_FULL;
  assign st_set[`MHA_ST_RXLVL] = rx_thresh != 4'h0 &&
                                 f_lvl[9:5] >= {1'b0, rx_thresh};
  wire pend = |(status & ~irq_mask);

  always @(posedge mclk) begin
    if (rst) begin
      status <= 8'h00;
      grant_q <= 1'b0;
      carrier_q <= 1'b0;
      pend_q <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      grant_q <= fsk_grant;
      carrier_q <= carrier_valid;
      pend_q <= pend;
      // a set in the clearing cycle survives
      status <= (status & ~status_clr) | (st_set & {8{spi_mode}});
      irq_out <= (irq_edge ? (pend && !pend_q) : pend) ^
                 ~irq_active_high;
    end
  end
endmodule // mha_arbiter

// >>> tb/mha_asserts.sv
// mha_asserts.sv - port checker for the modem transfer arbiter
// assumes a bind onto mha_arbiter, one clock, sync active-high reset
`timescale 1ns/1ps
module mha_asserts #(
  parameter [31:0] BABBLE_UNIT_CYC = 4,
  parameter [31:0] SILENCE_CYC = 20
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // modes and host link
  input wire spi_mode,
  input wire manch_mode,
  input wire uart_rts_n,
  input wire host_rx_valid,
  input wire [7:0] host_rx_data,
  input wire host_tx_valid,
  input wire [7:0] host_tx_data,
  input wire host_tx_par,
  input wire carrier_present_out,
  // bus side
  input wire carrier_valid,
  input wire bus_rx_valid,
  input wire [7:0] bus_rx_data,
  input wire [1:0] bus_rx_kind,
  input wire fsk_tx_valid,
  input wire [7:0] fsk_tx_data,
  input wire fsk_tx_par,
  // spi flags
  input wire [3:0] rx_thresh,
  input wire [4:0] spi_rx_level,
  input wire [4:0] spi_tx_level,
  input wire [7:0] status
);
  localparam int SIL_LO = SILENCE_CYC - 1;
  localparam int SIL_HI = SILENCE_CYC + 2;
  wire fsk = !spi_mode && !manch_mode;
  wire mu = !spi_mode && manch_mode;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fsk_rx_fwd: assert property (fsk && uart_rts_n && $past(uart_rts_n)
    && bus_rx_valid |=> host_tx_valid && host_tx_data == $past(bus_rx_data))
    else $error("received byte not passed to host");
  a_host_par: assert property (fsk && host_tx_valid
    |-> host_tx_par == ~^host_tx_data) else $error("host parity not odd");
  a_mod_par: assert property (fsk_tx_valid
    |-> fsk_tx_par == ~^fsk_tx_data) else $error("modulator parity not odd");
  a_cd_drop: assert property (fsk && carrier_present_out
    |-> !fsk_tx_valid) else $error("host byte sent while carrier shown");
  a_grant_fwd: assert property (fsk && !uart_rts_n && !carrier_valid
    ##1 fsk && !uart_rts_n && host_rx_valid
    |=> fsk_tx_valid && fsk_tx_data == $past(host_rx_data))
    else $error("granted byte not sent");
  a_strip_ctl: assert property (mu && bus_rx_valid && bus_rx_kind != 2'h0
    |=> !host_tx_valid) else $error("framing byte reached host");
  a_pass_data: assert property (mu && bus_rx_valid && bus_rx_kind == 2'h0
    |=> host_tx_valid && !host_tx_par && host_tx_data == $past(bus_rx_data))
    else $error("packet data byte not forwarded");
  a_silence_hold: assert property ($rose(carrier_present_out) && mu
    && !carrier_valid && !$past(carrier_valid) |-> carrier_present_out[*8])
    else $error("babble alarm dropped early");
  a_silence_end: assert property ($rose(carrier_present_out) && mu
    && !carrier_valid && !$past(carrier_valid)
    |-> ##[SIL_LO:SIL_HI] !carrier_present_out)
    else $error("babble alarm length wrong");
  a_rx_level: assert property (spi_mode && rx_thresh != 4'h0
    && spi_rx_level >= {1'b0, rx_thresh} |-> ##[0:2] status[7])
    else $error("rx level flag missing");
  a_fifo_depth: assert property (spi_tx_level <= 5'h10
    && spi_rx_level <= 5'h10) else $error("fifo count beyond depth");
  c_trip: cover property (mu && $rose(carrier_present_out));
  c_send: cover property (fsk_tx_valid);
  c_rx_lvl: cover property (spi_mode && status[7]);
endmodule // mha_asserts

// >>> tb/mha_host.sv
// mha_host.sv - host microcontroller on the uart byte link
// assumes whole characters arrive as one-cycle strobes on mclk
`timescale 1ns/1ps
module mha_host #(
  parameter int GAP_CYC = 64
) (
  input wire mclk,
  input wire host_tx_valid,
  output logic uart_rts_n,
  output logic host_rx_valid,
  output logic [7:0] host_rx_data,
  output logic pkt_end
);
  int gap = GAP_CYC;
  initial begin
    uart_rts_n = 1'h1;
    host_rx_valid = 1'h0;
    host_rx_data = 8'h00;
  end
  task automatic rts(input logic v);
    @(posedge mclk);
    uart_rts_n <= v;
  endtask
  // one whole character per strobe, framing done by the uart
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    host_rx_valid <= 1'h1;
    host_rx_data <= b;
    @(posedge mclk);
    host_rx_valid <= 1'h0;
    host_rx_data <= ~b; // released line shows no stale byte
    #1;
  endtask
  // scaled two-byte-spacing silence marks the end of a packet
  always @(posedge mclk) begin
    if (host_tx_valid)
      gap <= 0;
    else if (gap < GAP_CYC)
      gap <= gap + 1;
  end
  assign pkt_end = (gap >= GAP_CYC);
endmodule // mha_host

// >>> tb/tb.sv
// tb.sv - self-checking bench for the modem transfer arbiter
// assumes shortened babble unit and silence counts set below
`timescale 1ns/1ps
module tb;
  logic mclk = 1'h0, rst = 1'h1, spi_mode = 1'h0, manch_mode = 1'h0;
  logic ctl_rts = 1'h0, spi_tx_wr = 1'h0, spi_rx_rd = 1'h0;
  logic [8:0] spi_tx_data = 9'h000;
  logic [3:0] tx_thresh = 4'h0, rx_thresh = 4'h0;
  logic [7:0] irq_mask = 8'hFF, status_clr = 8'h00, bus_rx_data = 8'h00;
  logic carrier_valid = 1'h0, bus_rx_valid = 1'h0, fsk_tx_ready = 1'h0;
  logic [1:0] bus_rx_kind = 2'h0;
  logic [7:0] babble_limit_reg = 8'h00;
  logic [2:0] spi_pre_bytes = 3'h0;
  logic spi_invert = 1'h0, irq_edge = 1'h0, irq_active_high = 1'h1;
  wire uart_rts_n, host_rx_valid, host_tx_valid, host_tx_par, cpo;
  wire [7:0] host_rx_data, host_tx_data, fsk_tx_data, status;
  wire [8:0] spi_rx_data;
  wire [4:0] spi_tx_level, spi_rx_level;
  wire tx_alarm_out, irq_out, fsk_tx_valid, fsk_tx_par, manch_out, manch_oe;
  int error_cnt = 0, n_checks = 0, k, s, j, n, thr;
  logic inv;
  logic [39:0] bad [3];
  always #10 mclk = ~mclk;
  mha_host host_u (.mclk, .host_tx_valid, .uart_rts_n, .host_rx_valid,
    .host_rx_data, .pkt_end());
  mha_arbiter #(.BABBLE_UNIT_CYC(4), .SILENCE_CYC(20)) dut_u (.mclk, .rst,
    .spi_mode, .manch_mode, .uart_rts_n, .host_rx_valid, .host_rx_data,
    .host_tx_valid, .host_tx_data, .host_tx_par, .carrier_present_out(cpo),
    .tx_alarm_out, .ctl_rts, .spi_tx_wr, .spi_tx_data, .spi_rx_rd,
    .spi_rx_data, .spi_tx_level, .spi_rx_level, .tx_thresh, .rx_thresh,
    .babble_limit_reg, .spi_pre_bytes, .spi_invert,
    .irq_mask, .status_clr, .irq_edge, .irq_active_high,
    .status, .irq_out, .carrier_valid, .bus_rx_valid, .bus_rx_data,
    .bus_rx_kind, .fsk_tx_ready, .fsk_tx_valid, .fsk_tx_data, .fsk_tx_par,
    .manch_out, .manch_oe);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic bus(input logic [7:0] b, input logic [1:0] kd);
    bus_rx_valid <= 1'h1;
    bus_rx_data <= b;
    bus_rx_kind <= kd;
    tick(1);
    bus_rx_valid <= 1'h0;
    bus_rx_data <= ~b;
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1900000;
    error_cnt++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    bad = '{40'hEB98FFAE11, 40'hEA7FFFAE11, 40'hEA98FFAF11};
    tick(3);
    rst <= 1'h0;
    tick(2);
    check("idle carrier", cpo, 1'h0);
    check("idle irq", irq_out, 1'h0);
    // uart fsk arbitration
    carrier_valid <= 1'h1;
    bus(8'hA5, 2'h0);
    check("rx valid", host_tx_valid, 1'h1);
    check("rx data", host_tx_data, 8'hA5);
    check("rx parity", host_tx_par, 1'h1);
    check("carrier out", cpo, 1'h1);
    host_u.rts(1'h0);
    host_u.send(8'h3C);
    check("tx blocked", fsk_tx_valid, 1'h0);
    carrier_valid <= 1'h0;
    host_u.rts(1'h1);
    tick(3);
    host_u.rts(1'h0);
    tick(2);
    host_u.send(8'h3C);
    check("tx valid", fsk_tx_valid, 1'h1);
    check("tx data", fsk_tx_data, 8'h3C);
    check("tx parity", fsk_tx_par, 1'h1);
    carrier_valid <= 1'h1;
    bus(8'h5A, 2'h0);
    check("rx in tx", host_tx_valid, 1'h0);
    check("carrier in tx", cpo, 1'h0);
    carrier_valid <= 1'h0;
    host_u.rts(1'h1);
    // uart manchester receive
    manch_mode <= 1'h1;
    tick(3);
    for (k = 0; k < 4; k++) begin
      bus(8'h7E, k[1:0]);
      check("strip", host_tx_valid, k == 0);
      tick(1);
    end
    tick(70);
    check("pkt end", host_u.pkt_end, 1'h1);
    // malformed openings never start the encoder
    for (s = 0; s < 3; s++) begin
      for (j = 4; j >= 0; j--)
        host_u.send(bad[s][j*8 +: 8]);
      tick(10);
      check("bad open", manch_oe, 1'h0);
    end
    // every alarm level and both polarities, cut short by babble
    for (s = 0; s < 4; s++) begin
      inv = s[0];
      thr = 2 * (s + 1);
      host_u.send(inv ? 8'h15 : 8'hEA);
      host_u.send({inv ? 3'h3 : 3'h4, s[1:0], 3'h0});
      host_u.send(8'hFF);
      host_u.send(inv ? 8'h51 : 8'hAE);
      for (k = 1; k <= thr + 1; k++) begin
        host_u.send(k[7:0]);
        tick(2);
        check("alarm", tx_alarm_out, k <= thr);
      end
      check("sending", manch_oe, 1'h1);
      check("first half", manch_out, inv);
      n = 0;
      while (cpo !== 1'h1 && n < 1200) begin
        tick(1);
        n++;
      end
      check("trip time", n > 900 && n < 1030, 1'h1);
      tick(3);
      check("trip stop", manch_oe, 1'h0);
      check("trip alarm", cpo, 1'h1);
      tick(25);
      check("silence end", cpo, 1'h0);
    end
    // full packet: two preambles, start, one byte, stop
    host_u.send(8'hEA);
    host_u.send(8'h81);
    host_u.send(8'h00);
    host_u.send(8'hAE);
    host_u.send(8'hC3);
    tick(10);
    n = 0;
    while (manch_oe === 1'h1 && n < 70000) begin
      tick(1);
      n++;
    end
    check("pkt len", n >= 63990 && n <= 64010, 1'h1);
    check("no trip", cpo, 1'h0);
    host_u.send(8'hC3);
    tick(10);
    check("needs open", manch_oe, 1'h0);
    // spi mode fifos and flags
    spi_mode <= 1'h0 | 1'h1;
    manch_mode <= 1'h0;
    irq_mask <= 8'h7D;
    rx_thresh <= 4'h2;
    rst <= 1'h1;
    tick(2);
    rst <= 1'h0;
    carrier_valid <= 1'h1;
    tick(4);
    check("cd flag", status[1], 1'h1);
    check("cd irq", irq_out, 1'h1);
    status_clr <= 8'hFF;
    tick(1);
    status_clr <= 8'h00;
    tick(2);
    check("cleared irq", irq_out, 1'h0);
    bus(8'h11, 2'h0);
    tick(1);
    bus(8'h26, 2'h2);
    tick(3);
    check("rx level", spi_rx_level, 5'h02);
    check("rx flag", status[7], 1'h1);
    check("rx irq", irq_out, 1'h1);
    check("rx head", spi_rx_data, 9'h011);
    spi_rx_rd <= 1'h1;
    tick(1);
    spi_rx_rd <= 1'h0;
    tick(1);
    check("rx tag", spi_rx_data, 9'h126);
    tx_thresh <= 4'h4;
    spi_tx_wr <= 1'h1;
    for (k = 0; k < 17; k++) begin
      spi_tx_data <= k[8:0];
      tick(1);
    end
    spi_tx_wr <= 1'h0;
    tick(2);
    check("tx full", spi_tx_level, 5'h10);
    check("tx full flag", status[5], 1'h1);
    check("tx lvl flag", status[4], 1'h1);
    carrier_valid <= 1'h0;
    ctl_rts <= 1'h1;
    tick(3);
    check("grant flag", status[0], 1'h1);
    fsk_tx_ready <= 1'h1;
    tick(40);
    check("drain", spi_tx_level, 5'h00);
    // spi manchester: inverted line, babble trip, active-low edge irq
    ctl_rts <= 1'h0;
    manch_mode <= 1'h1;
    babble_limit_reg <= 8'h02;
    spi_pre_bytes <= 3'h2;
    spi_invert <= 1'h1;
    irq_mask <= 8'hF3;
    irq_edge <= 1'h1;
    irq_active_high <= 1'h0;
    status_clr <= 8'hFF;
    tick(2);
    status_clr <= 8'h00;
    spi_tx_wr <= 1'h1;
    spi_tx_data <= 9'h0A5;
    tick(1);
    spi_tx_wr <= 1'h0;
    tick(4);
    check("spi sending", manch_oe, 1'h1);
    check("spi inverted", manch_out, 1'h1);
    n = 0;
    while (status[2] !== 1'h1 && n < 50) begin
      tick(1);
      n++;
    end
    check("spi trip", status[2], 1'h1);
    check("irq idle", irq_out, 1'h1);
    tick(1);
    check("trip irq", irq_out, 1'h0);
    tick(1);
    check("irq pulse", irq_out, 1'h1);
    check("spi blocked", manch_oe, 1'h0);
    check("no end yet", status[3], 1'h0);
    tick(20);
    check("end flag", status[3], 1'h1);
    give_verdict();
  end
endmodule // tb
bind mha_arbiter mha_asserts #(.BABBLE_UNIT_CYC(BABBLE_UNIT_CYC),
  .SILENCE_CYC(SILENCE_CYC)) chk_u (.mclk, .rst, .spi_mode, .manch_mode,
  .uart_rts_n, .host_rx_valid, .host_rx_data, .host_tx_valid, .host_tx_data,
  .host_tx_par, .carrier_present_out, .carrier_valid, .bus_rx_valid,
  .bus_rx_data, .bus_rx_kind, .fsk_tx_valid, .fsk_tx_data, .fsk_tx_par,
  .rx_thresh, .spi_rx_level, .spi_tx_level, .status);
